// >>> rtl/iap_consts.svh
// Constants for the flash programming control block: register offsets,
// field positions, reset values, unlock key and timing figures.
// Assumes a 40 MHz system clock and a byte-addressed AXI4-Lite window.
`ifndef IAP_CONSTS_SVH
`define IAP_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define IAP_OFS_ADDR_LOW   6'h00
`define IAP_OFS_ADDR_HIGH  6'h04
`define IAP_OFS_DATA0_LOW  6'h08
`define IAP_OFS_DATA3_HIGH 6'h24
`define IAP_OFS_OP_CTRL    6'h28
`define IAP_OFS_RST_KEY    6'h2C

// ****************************************************************
// Register word indices
// ****************************************************************
`define IAP_IDX_ADDR_LOW   4'h0
`define IAP_IDX_ADDR_HIGH  4'h1
`define IAP_IDX_DATA0_LOW  4'h2
`define IAP_IDX_DATA0_HIGH 4'h3
`define IAP_IDX_DATA3_HIGH 4'h9
`define IAP_IDX_OP_CTRL    4'hA
`define IAP_IDX_RST_KEY    4'hB

// ****************************************************************
// Control register fields and reset values
// ****************************************************************
`define IAP_BIT_UNLOCKED   7
`define IAP_BIT_TRIGGER    3
`define IAP_BIT_PROG_GO    2
`define IAP_BIT_RD_PERMIT  1
`define IAP_BIT_RD_GO      0
`define IAP_RST_BYTE       8'h00
`define IAP_MODE_WRITE     3'h0
`define IAP_MODE_ERASE     3'h1
`define IAP_MODE_READ      3'h3
`define IAP_MODE_UNLOCK    3'h6
`define IAP_HIGH_ADDR_W    5
`define IAP_PAGE_LAST      5'h1F
`define IAP_CHIP_RST_KEY   8'h55

// ****************************************************************
// Unlock key, second to fourth data pairs
// ****************************************************************
`define IAP_KEY1_LOW       8'h00
`define IAP_KEY2_LOW       8'h0D
`define IAP_KEY3_LOW       8'hC3
`define IAP_KEY1_HIGH      8'h04
`define IAP_KEY2_HIGH      8'h09
`define IAP_KEY3_HIGH      8'h40

// ****************************************************************
// Timing
// ****************************************************************
`define IAP_CLK_HZ         40000000
`define IAP_CLK_PERIOD_NS  25
`define IAP_SUB_HZ         32768
`define IAP_SUB_DIV        (`IAP_CLK_HZ / `IAP_SUB_HZ)
`define IAP_PROG_TIME_NS   2200000
`define IAP_UNLOCK_TICKS   64

// ****************************************************************
// AXI responses
// ****************************************************************
`define IAP_RESP_OKAY      2'h0
`define IAP_RESP_SLVERR    2'h2

`endif

// >>> rtl/iap_flash_ctrl.sv
// Flash programming control: AXI4-Lite register file, unlock sequence,
// page write buffer loading and erase/write/read sequencing.
// Assumes a flash array on the same clock that takes one word per
// cycle on write and answers a read request with an acknowledge.
//
// Contract
// - High address keeps bits 12..8, upper zero
// - Low data write only stores itself
// - High data write loads word into buffer
// - Address pair increments after each load
// - Clearing unlocked bit disables erase/write
// - Software cannot set unlocked; hardware does
// - Mode codes: write, erase, read, unlock
// - Trigger starts timer; expiry clears trigger
// - Program go starts; hardware clears when done
// - Reads blocked without read permit
// - Read go starts read; cleared when done
// - CPU stalled while erase, write or read runs
// - Key 55H resets whole chip
// - Unlock key pattern in data pairs 1-3
// - Wrong key leaves erase/write locked
// - Buffer is one page, address stops
// - Erase or write lasts 2.2 ms
`timescale 1ns/10ps
`include "iap_consts.svh"
module iap_flash_ctrl
  import iap_pkg::*;
#(
  parameter int PROG_CYCLES  = `IAP_PROG_TIME_NS / `IAP_CLK_PERIOD_NS,
  parameter int UNLOCK_TICKS = `IAP_UNLOCK_TICKS
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [5:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  output logic      [1:0]  s_axi_bresp_o,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  input  wire logic [5:0]  s_axi_araddr_i,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic      [31:0] s_axi_rdata_o,
  output logic      [1:0]  s_axi_rresp_o,
  // Flash array
  output iap_flash_req_t   flash_req_o,
  input  wire logic        flash_rd_ack_i,
  input  wire logic [15:0] flash_rd_data_i,
  // System
  output logic             cpu_stall_o,
  output logic             chip_reset_o
);

  // ****************************************************************
  // Local state
  // ****************************************************************
  // Registers and sequencer share one packed struct, so reset and the
  // next-state copy can never drift apart.
  iap_regs_t   s;
  iap_regs_t   next_s;
  logic        wb_we;
  logic        wb_clr;
  logic [15:0] wb_wdata;
  logic [15:0] wb_rdata;
  logic        wr_fire;
  logic        rd_fire;
  logic [3:0]  widx_reg;
  logic [3:0]  ridx_reg;
  logic        sub_tick;
  logic        key_ok;
  logic        set_unl;
  logic [2:0]  wmode;

  // ****************************************************************
  // Register read view
  // ****************************************************************
  function automatic logic [31:0] reg_view(input iap_regs_t r,
                                           input logic [3:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (idx)
      `IAP_IDX_ADDR_LOW:  v[7:0] = r.addr[7:0];
      `IAP_IDX_ADDR_HIGH: v[`IAP_HIGH_ADDR_W-1:0] = r.addr[12:8];
      `IAP_IDX_OP_CTRL:   v[7:0] = {r.unlocked, r.mode, r.trig, r.prog_go,
                                    r.rd_permit, r.rd_go};
      `IAP_IDX_RST_KEY:   v[7:0] = r.rst_key;
      default: begin
        if (idx >= `IAP_IDX_DATA0_LOW && idx <= `IAP_IDX_DATA3_HIGH) begin
          v[7:0] = r.data[3'(idx - `IAP_IDX_DATA0_LOW)];
        end
      end
    endcase
    return v;
  endfunction

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // Write ready follows valid combinationally; a new write waits until the
  // previous response has been accepted, so one write is in flight.
  // Both channels are taken together so the write never splits.
  assign wr_fire         = s_axi_awvalid_i && s_axi_wvalid_i && !s.bvalid;
  assign rd_fire         = s_axi_arvalid_i && !s.rvalid;
  assign s_axi_awready_o = wr_fire;
  assign s_axi_wready_o  = wr_fire;
  assign s_axi_arready_o = !s.rvalid;
  assign widx_reg        = s_axi_awaddr_i[5:2];
  assign ridx_reg        = s_axi_araddr_i[5:2];
  assign wmode           = s_axi_wdata_i[6:4];

  // ****************************************************************
  // Unlock key compare
  // ****************************************************************
  // The key is judged only when the timer expires, so the order in which
  // software fills the data pairs does not matter.
  // unlock key pattern
  assign key_ok = (s.data[2] == `IAP_KEY1_LOW)  &&
                  (s.data[3] == `IAP_KEY1_HIGH) &&
                  (s.data[4] == `IAP_KEY2_LOW)  &&
                  (s.data[5] == `IAP_KEY2_HIGH) &&
                  (s.data[6] == `IAP_KEY3_LOW)  &&
                  (s.data[7] == `IAP_KEY3_HIGH);

  // Sub clock tick: one enable pulse per divider period. The ratio is
  // rounded down, so the unlock window is slightly shorter than nominal.
  assign sub_tick = (s.sub_div == 11'(`IAP_SUB_DIV - 1));

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s           = s;
    wb_we            = 1'b0;
    wb_clr           = 1'b0;
    wb_wdata         = {s_axi_wdata_i[7:0], s.data[0]};
    set_unl          = 1'b0;
    next_s.chip_rst  = 1'b0;
    next_s.freq.erase = 1'b0;
    next_s.freq.wr_en = 1'b0;
    next_s.sub_div   = sub_tick ? 11'h000 : s.sub_div + 11'h001;

    if (s.trig && sub_tick) begin
      if (s.unl_cnt == 8'(UNLOCK_TICKS - 1)) begin
        next_s.trig    = 1'b0;
        next_s.unl_cnt = 8'h00;
        set_unl        = key_ok && (s.mode == `IAP_MODE_UNLOCK);
      end else begin
        next_s.unl_cnt = s.unl_cnt + 8'h01;
      end
    end

    if (wr_fire) begin
      next_s.bvalid = 1'b1;
      next_s.bresp  = (s_axi_awaddr_i <= `IAP_OFS_RST_KEY) ?
                      `IAP_RESP_OKAY : `IAP_RESP_SLVERR;
      if (s_axi_wstrb_i[0] && s_axi_awaddr_i <= `IAP_OFS_RST_KEY) begin
        case (widx_reg)
          `IAP_IDX_ADDR_LOW: next_s.addr[7:0] = s_axi_wdata_i[7:0];
          `IAP_IDX_ADDR_HIGH: begin
            next_s.addr[12:8] = s_axi_wdata_i[`IAP_HIGH_ADDR_W-1:0];
          end
          `IAP_IDX_DATA0_LOW: next_s.data[0] = s_axi_wdata_i[7:0];
          `IAP_IDX_DATA0_HIGH: begin
            next_s.data[1] = s_axi_wdata_i[7:0];
            if (s.unlocked) begin
              wb_we = 1'b1;
              if (s.addr[4:0] != `IAP_PAGE_LAST) begin
                next_s.addr = s.addr + 13'h0001;
              end
            end
          end
          `IAP_IDX_OP_CTRL: begin
            next_s.unlocked  = s.unlocked & s_axi_wdata_i[`IAP_BIT_UNLOCKED];
            next_s.mode      = wmode;
            next_s.rd_permit = s_axi_wdata_i[`IAP_BIT_RD_PERMIT];
            if (s_axi_wdata_i[`IAP_BIT_TRIGGER] && !s.trig) begin
              next_s.trig    = 1'b1;
              next_s.unl_cnt = 8'h00;
            end
            if (s.st == IAP_ST_IDLE) begin
              // start erase or write when unlocked
              if (s_axi_wdata_i[`IAP_BIT_PROG_GO] && next_s.unlocked &&
                  (wmode == `IAP_MODE_WRITE || wmode == `IAP_MODE_ERASE)) begin
                next_s.prog_go = 1'b1;
                next_s.widx    = 5'h00;
                next_s.st      = (wmode == `IAP_MODE_ERASE) ?
                                 IAP_ST_ERASE : IAP_ST_WRITE;
              end else if (s_axi_wdata_i[`IAP_BIT_RD_GO] && s.rd_permit &&
                           wmode == `IAP_MODE_READ) begin
                next_s.rd_go       = 1'b1;
                next_s.freq.rd_req = 1'b1;
                next_s.freq.addr   = s.addr;
                next_s.st          = IAP_ST_READ;
              end
            end
          end
          `IAP_IDX_RST_KEY: begin
            next_s.rst_key = s_axi_wdata_i[7:0];
            next_s.chip_rst = (s_axi_wdata_i[7:0] == `IAP_CHIP_RST_KEY);
          end
          default: begin
            next_s.data[3'(widx_reg - `IAP_IDX_DATA0_LOW)] =
              s_axi_wdata_i[7:0];
          end
        endcase
      end
    end else if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end

    if (rd_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = reg_view(s, ridx_reg);
      next_s.rresp  = (s_axi_araddr_i <= `IAP_OFS_RST_KEY) ?
                      `IAP_RESP_OKAY : `IAP_RESP_SLVERR;
    end else if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid = 1'b0;
    end

    // ****************************************************************
    // Operation sequencer
    // ****************************************************************
    case (s.st)
      IAP_ST_IDLE: begin
      end
      IAP_ST_ERASE: begin
        next_s.freq.erase = 1'b1;
        next_s.freq.addr  = {s.addr[12:5], 5'h00};
        next_s.prog_cnt   = 17'h00000;
        next_s.st         = IAP_ST_WAIT;
      end
      IAP_ST_WRITE: begin
        next_s.freq.wr_en = 1'b1;
        next_s.freq.addr  = {s.addr[12:5], s.widx};
        next_s.freq.wdata = wb_rdata;
        next_s.widx       = s.widx + 5'h01;
        next_s.prog_cnt   = 17'h00000;
        if (s.widx == `IAP_PAGE_LAST) begin
          next_s.st = IAP_ST_WAIT;
        end
      end
      IAP_ST_WAIT: begin
        // The array gives no done signal for programming; the wait is a
        // fixed count, so a slower array needs a larger PROG_CYCLES.
        // programming time
        if (s.prog_cnt == 17'(PROG_CYCLES - 1)) begin
          next_s.prog_go = 1'b0;
          next_s.st      = IAP_ST_IDLE;
          wb_clr         = (s.mode == `IAP_MODE_WRITE);
        end else begin
          next_s.prog_cnt = s.prog_cnt + 17'h00001;
        end
      end
      IAP_ST_READ: begin
        // The address was latched at start, so a later address write
        // cannot change the word being fetched.
        if (flash_rd_ack_i) begin
          next_s.data[0]     = flash_rd_data_i[7:0];
          next_s.data[1]     = flash_rd_data_i[15:8];
          next_s.rd_go       = 1'b0;
          next_s.freq.rd_req = 1'b0;
          next_s.st          = IAP_ST_IDLE;
        end
      end
      default: begin
        next_s.st = IAP_ST_IDLE;
      end
    endcase

    // A hardware unlock beats a software clear in the same cycle.
    if (set_unl) begin
      next_s.unlocked = 1'b1;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      s          <= '0;
      s.st       <= IAP_ST_IDLE;
      s.bresp    <= `IAP_RESP_OKAY;
      s.rresp    <= `IAP_RESP_OKAY;
      s.rst_key  <= `IAP_RST_BYTE;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Page write buffer
  // ****************************************************************
  // Loads use the live address; the burst reads by the sequencer index.
  iap_wbuf u_wbuf (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .clr_i   (wb_clr),
    .we_i    (wb_we),
    .widx_i  (s.addr[4:0]),
    .wdata_i (wb_wdata),
    .ridx_i  (s.widx),
    .rdata_o (wb_rdata)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_bvalid_o = s.bvalid;
  assign s_axi_bresp_o  = s.bresp;
  assign s_axi_rvalid_o = s.rvalid;
  assign s_axi_rdata_o  = s.rdata;
  assign s_axi_rresp_o  = s.rresp;
  assign flash_req_o    = s.freq;
  assign cpu_stall_o    = (s.st != IAP_ST_IDLE);
  assign chip_reset_o   = s.chip_rst;

endmodule // iap_flash_ctrl

// >>> rtl/iap_pkg.sv
// Types shared by the flash programming control block.
// Assumes the constants header is on the include path.
package iap_pkg;

  typedef enum logic [4:0] {
    IAP_ST_IDLE  = 5'h01,
    IAP_ST_ERASE = 5'h02,
    IAP_ST_WRITE = 5'h04,
    IAP_ST_WAIT  = 5'h08,
    IAP_ST_READ  = 5'h10
  } iap_state_t;

  // Request towards the flash array.
  typedef struct packed {
    logic        erase;
    logic        wr_en;
    logic        rd_req;
    logic [12:0] addr;
    logic [15:0] wdata;
  } iap_flash_req_t;

  typedef struct packed {
    iap_state_t       st;
    logic [12:0]      addr;
    logic [7:0][7:0]  data;
    logic             unlocked;
    logic [2:0]       mode;
    logic             trig;
    logic             prog_go;
    logic             rd_permit;
    logic             rd_go;
    logic [7:0]       rst_key;
    logic [10:0]      sub_div;
    logic [7:0]       unl_cnt;
    logic [16:0]      prog_cnt;
    logic [4:0]       widx;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    iap_flash_req_t   freq;
    logic             chip_rst;
  } iap_regs_t;

endpackage

// >>> rtl/iap_wbuf.sv
// Page write buffer: 32 words of 16 bits, one write port and one
// combinational read port, cleared as a whole in one cycle.
// Assumes the controller serialises writes, reads and clears.
`timescale 1ns/10ps
module iap_wbuf
  import iap_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // Load and clear
  input  wire logic        clr_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  widx_i,
  input  wire logic [15:0] wdata_i,
  // Read
  input  wire logic [4:0]  ridx_i,
  output logic      [15:0] rdata_o
);

  logic [15:0] mem [32];

  // ****************************************************************
  // Storage
  // ****************************************************************
  for (genvar i = 0; i < 32; i++) begin : g_word
    always_ff @(posedge mclk_i) begin
      if (!rst_b_i || clr_i) begin
        mem[i] <= 16'h0000;
      end else if (we_i && (widx_i == 5'(i))) begin
        mem[i] <= wdata_i;
      end
    end
  end

  assign rdata_o = mem[ridx_i];

endmodule // iap_wbuf

// >>> tb/iap_flash_model.sv
// Behavioural flash array behind the control block.
// Assumes requests on the system clock; read delay set by the bench.
`timescale 1ns/10ps
module iap_flash_model
  import iap_pkg::*;
(
  // Clock and request
  input  wire logic           mclk_i,
  input  wire iap_flash_req_t req_i,
  input  wire logic [3:0]     delay_i,
  // Read answer
  output logic                ack_o,
  output logic [15:0]         data_o
);
  logic [15:0] mem [0:8191];
  logic [3:0]  wait_q = 4'h0;
  initial ack_o = 1'b0;
  initial data_o = 16'hA5A5;
  // Outside an answer the data toggles, so stale data cannot match.
  always @(posedge mclk_i) begin
    ack_o <= 1'b0;
    data_o <= ~data_o;
    if (req_i.erase) begin
      for (int i = 0; i < 32; i++) mem[{req_i.addr[12:5], 5'(i)}] = 16'h0;
    end
    if (req_i.wr_en) mem[req_i.addr] = req_i.wdata;
    if (req_i.rd_req && !ack_o) begin
      if (wait_q >= delay_i) begin
        ack_o <= 1'b1;
        data_o <= mem[req_i.addr];
        wait_q <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule // iap_flash_model

// >>> tb/iap_props.sv
// Port checker for the flash programming control block.
// Assumes it is bound to iap_flash_ctrl and sees only its ports.
`timescale 1ns/10ps
`include "iap_consts.svh"
module iap_props
  import iap_pkg::*;
#(
  parameter int PROG_CYCLES = 20
) (
  // Clock and reset
  input wire logic           mclk_i,
  input wire logic           rst_b_i,
  // Register bus
  input wire logic           s_axi_awvalid_i,
  input wire logic           s_axi_awready_o,
  input wire logic [5:0]     s_axi_awaddr_i,
  input wire logic           s_axi_wvalid_i,
  input wire logic [31:0]    s_axi_wdata_i,
  input wire logic [3:0]     s_axi_wstrb_i,
  input wire logic           s_axi_bvalid_o,
  input wire logic [1:0]     s_axi_bresp_o,
  input wire logic           s_axi_arvalid_i,
  input wire logic           s_axi_arready_o,
  input wire logic [5:0]     s_axi_araddr_i,
  input wire logic           s_axi_rvalid_o,
  input wire logic [31:0]    s_axi_rdata_o,
  // Flash and system
  input wire iap_flash_req_t flash_req_o,
  input wire logic           flash_rd_ack_i,
  input wire logic           cpu_stall_o,
  input wire logic           chip_reset_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic        wr_take;
  logic        rd_take;
  logic        after_prog;
  logic [19:0] prog_cnt;
  assign wr_take = s_axi_awvalid_i & s_axi_wvalid_i & s_axi_awready_o;
  assign rd_take = s_axi_arvalid_i & s_axi_arready_o;
  // The count restarts at every erase pulse or word, so a burst is
  // timed from its last word; a read in between forgets the operation.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i || flash_req_o.erase || flash_req_o.wr_en) begin
      prog_cnt <= '0;
    end else if (cpu_stall_o) begin
      prog_cnt <= prog_cnt + 20'h1;
    end
    if (!rst_b_i || flash_req_o.rd_req) begin
      after_prog <= 1'b0;
    end else if (flash_req_o.erase || flash_req_o.wr_en) begin
      after_prog <= 1'b1;
    end
  end
  sequence s_burst_step;
    flash_req_o.wr_en ##1 flash_req_o.wr_en;
  endsequence
  sequence s_read_ack;
    flash_req_o.rd_req && flash_rd_ack_i;
  endsequence
  a_write_answer: assert property (wr_take |=> s_axi_bvalid_o)
    else $error("write not answered");
  a_read_answer: assert property (rd_take |=> s_axi_rvalid_o)
    else $error("read not answered");
  a_unmapped_err: assert property (wr_take && s_axi_awaddr_i > 6'h2C
    |=> s_axi_bresp_o == `IAP_RESP_SLVERR) else $error("unmapped accepted");
  a_high_addr_zero: assert property (rd_take && s_axi_araddr_i == 6'h04
    |=> s_axi_rdata_o[31:5] == 27'h0) else $error("high address bits set");
  a_chip_reset: assert property (wr_take && s_axi_awaddr_i == 6'h2C
    && s_axi_wstrb_i[0] && s_axi_wdata_i[7:0] == `IAP_CHIP_RST_KEY
    |-> ##[1:2] chip_reset_o) else $error("no chip reset");
  a_stall_busy: assert property (flash_req_o.erase || flash_req_o.wr_en
    || flash_req_o.rd_req |-> cpu_stall_o) else $error("flash busy unstalled");
  a_page_first: assert property ($rose(flash_req_o.wr_en)
    |-> flash_req_o.addr[4:0] == 5'h00) else $error("burst not at page base");
  a_page_step: assert property (s_burst_step
    |-> flash_req_o.addr[4:0] == $past(flash_req_o.addr[4:0]) + 5'h01)
    else $error("burst address skipped");
  a_read_finish: assert property (s_read_ack
    |=> !flash_req_o.rd_req ##[0:1] !cpu_stall_o) else $error("read hangs");
  a_prog_time: assert property ($fell(cpu_stall_o) && after_prog
    |-> prog_cnt >= PROG_CYCLES - 1 && prog_cnt <= PROG_CYCLES + 1)
    else $error("program time wrong");
endmodule // iap_props
bind iap_flash_ctrl iap_props #(.PROG_CYCLES(PROG_CYCLES)) u_iap_props (
  .mclk_i, .rst_b_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_awaddr_i,
  .s_axi_wvalid_i, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_bvalid_o,
  .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_araddr_i,
  .s_axi_rvalid_o, .s_axi_rdata_o, .flash_req_o, .flash_rd_ack_i,
  .cpu_stall_o, .chip_reset_o);

// >>> tb/tb_top.sv
// Self-checking bench for the flash programming control block.
// Assumes design, checker and flash model are compiled first.
`timescale 1ns/10ps
`include "iap_consts.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_top
  import iap_pkg::*;
;
  logic           clk = 0, rst_b = 0, awv = 0, wv = 0, bry = 0;
  logic           arv = 0, rry = 0, awr, wrd, bv, arr, rv, ack, stall, crst;
  logic [5:0]     awa = 0, ara = 0;
  logic [31:0]    wd = 0, rd;
  logic [3:0]     ws = 4'hF, dly = 0;
  logic [1:0]     br, rr;
  logic [15:0]    fdat, w;
  logic [15:0]    img [0:31];
  logic [12:0]    a;
  logic [2:0]     rsv [4] = '{3'h2, 3'h4, 3'h5, 3'h7};
  iap_flash_req_t freq;
  int             n_errors = 0, n_tests = 0, seed = 32'hed68, cyc = 0;
  int             n_crst = 0, j;
  initial forever #12.5 clk = ~clk;
  iap_flash_ctrl #(.PROG_CYCLES(20), .UNLOCK_TICKS(2)) u_iap_flash_ctrl (
    .mclk_i(clk), .rst_b_i(rst_b), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_bresp_o(br),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .s_axi_rdata_o(rd),
    .s_axi_rresp_o(rr), .flash_req_o(freq), .flash_rd_ack_i(ack),
    .flash_rd_data_i(fdat), .cpu_stall_o(stall), .chip_reset_o(crst));
  iap_flash_model u_iap_flash_model (.mclk_i(clk), .req_i(freq),
    .delay_i(dly), .ack_o(ack), .data_o(fdat));
  // ****************************************************************
  // Bus tasks and expectations
  // ****************************************************************
  task automatic wr(input logic [5:0] ad, input logic [7:0] d,
                    input logic [1:0] er = `IAP_RESP_OKAY);
    awa <= ad; wd <= {24'h0, d}; awv <= 1'b1; wv <= 1'b1;
    do @(negedge clk); while (!awr);
    @(posedge clk);
    awv <= 1'b0; wv <= 1'b0; bry <= 1'b1;
    do @(negedge clk); while (!bv);
    `CHK(br, er)
    @(posedge clk);
    bry <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] ad, input logic [31:0] m, e,
                      input logic [1:0] er = `IAP_RESP_OKAY);
    ara <= ad; arv <= 1'b1;
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 1'b0; rry <= 1'b1;
    do @(negedge clk); while (!rv);
    `CHK(rd & m, e)
    `CHK(rr, er)
    @(posedge clk);
    rry <= 1'b0;
  endtask
  task automatic poll(input int b);
    do begin
      ara <= 6'h28; arv <= 1'b1;
      do @(negedge clk); while (!arr);
      @(posedge clk);
      arv <= 1'b0; rry <= 1'b1;
      do @(negedge clk); while (!rv);
      @(posedge clk);
      rry <= 1'b0;
    end while (rd[b] !== 1'b0);
  endtask
  // Key is written straight after the trigger, before the timer runs out.
  task automatic unlock(input logic [7:0] k3h);
    wr(6'h28, 8'h68);
    wr(6'h10, `IAP_KEY1_LOW); wr(6'h14, `IAP_KEY1_HIGH);
    wr(6'h18, `IAP_KEY2_LOW); wr(6'h1C, `IAP_KEY2_HIGH);
    wr(6'h20, `IAP_KEY3_LOW); wr(6'h24, k3h);
    rchk(6'h28, 32'h08, 32'h08);
    poll(`IAP_BIT_TRIGGER);
  endtask
  function automatic logic [12:0] nxt(input logic [12:0] x);
    return (x[4:0] == 5'h1F) ? x : x + 13'h1;
  endfunction
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (crst === 1'b1) n_crst++;
    if (cyc == 40000) begin
      n_errors++;
      $display("unexpected at %0t: run too long", $time);
      report_and_stop();
    end
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 1; i < 12; i++) rchk(6'(4 * i), 32'hFFFFFFFF, 0);
    wr(6'h04, 8'hFF);
    rchk(6'h04, 32'hFFFFFFFF, 32'h1F);
    wr(6'h30, 8'h11, `IAP_RESP_SLVERR);
    rchk(6'h3C, 32'hFFFFFFFF, 0, `IAP_RESP_SLVERR);
    wr(6'h28, 8'h80);
    rchk(6'h28, 32'h80, 0);
    done("registers");
    unlock(8'h41);
    rchk(6'h28, 32'h80, 0);
    unlock(`IAP_KEY3_HIGH);
    rchk(6'h28, 32'h80, 32'h80);
    done("unlock");
    a = {8'($random(seed)), 5'h00};
    wr(6'h04, {3'h0, a[12:8]}); wr(6'h00, a[7:0]);
    // erase the page at the random address while unlocked
    wr(6'h28, 8'h94);
    @(negedge clk);
    `CHK(stall, 1'b1)
    @(posedge clk);
    poll(`IAP_BIT_PROG_GO);
    wr(6'h28, 8'h80);
    wr(6'h08, 8'h5A);
    rchk(6'h00, 32'hFF, {24'h0, a[7:0]});
    for (int i = 0; i < 33; i++) begin
      w = 16'($random(seed));
      img[(i > 31) ? 31 : i] = w;
      wr(6'h08, w[7:0]); wr(6'h0C, w[15:8]);
      a = nxt(a);
      if (i == 0) rchk(6'h00, 32'hFF, {24'h0, a[7:0]});
    end
    rchk(6'h00, 32'hFF, {24'h0, a[7:0]});
    wr(6'h28, 8'h84);
    @(negedge clk);
    `CHK(stall, 1'b1)
    @(posedge clk);
    poll(`IAP_BIT_PROG_GO);
    done("program");
    wr(6'h28, 8'hB1);
    @(negedge clk);
    `CHK(stall, 1'b0)
    @(posedge clk);
    rchk(6'h28, 32'h01, 0);
    wr(6'h28, 8'hB2);
    for (int i = 0; i < 4; i++) begin
      j = (i == 0) ? 0 : (i == 1) ? 31 : ($random(seed) & 31);
      dly <= 4'($random(seed));
      wr(6'h00, {a[7:5], 5'(j)});
      wr(6'h28, 8'hB3);
      poll(`IAP_BIT_RD_GO);
      rchk(6'h08, 32'hFF, {24'h0, img[j][7:0]});
      rchk(6'h0C, 32'hFF, {24'h0, img[j][15:8]});
    end
    done("read");
    foreach (rsv[k]) begin
      wr(6'h28, {1'b1, rsv[k], 4'h4});
      rchk(6'h28, 32'h04, 0);
    end
    wr(6'h28, 8'h00);
    rchk(6'h28, 32'h80, 0);
    wr(6'h28, 8'h14);
    rchk(6'h28, 32'h04, 0);
    wr(6'h00, 8'h00); wr(6'h0C, 8'h12);
    rchk(6'h00, 32'hFF, 0);
    done("lock");
    wr(6'h2C, 8'h54);
    wr(6'h2C, `IAP_CHIP_RST_KEY);
    repeat (3) @(posedge clk);
    `CHK(n_crst, 1)
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rchk(6'h28, 32'hFF, 0);
    done("chip reset");
    report_and_stop();
  end
endmodule // tb_top
